// ==== verif/tabs_chk.sv ====
`timescale 1ns/1ps
module tabs_chk (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic linkStrobe,
  input wire logic linkFirst,
  input wire logic [7:0] linkByte,
  input wire logic [7:0] devByte,
  input wire logic devByteValid,
  input wire logic busy
);
  // ----------------------------------------------------------------
  // Link frame checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  sequence rd_thr;
    linkFirst && linkByte == 8'h55 ##1 linkByte[7:4] == 4'hA ##2 linkStrobe;
  endsequence
  sequence wr_conv;
    linkFirst && linkByte == 8'h54 ##1 linkByte == 8'h62 ##2 linkStrobe && !linkByte[2];
  endsequence
  init_busy_a: assert property ($rose(resetn) |-> busy [*8]) else $error("busy low");
  init_end_a: assert property ($rose(resetn) |-> ##[240:260] !busy)
    else $error("busy stuck");
  first_strobe_a: assert property (linkFirst |-> linkStrobe) else $error("bare first");
  frame_len_a: assert property (linkFirst |=> (linkStrobe && !linkFirst) [*3])
    else $error("short frame");
  thr_read_a: assert property (rd_thr |-> devByteValid && devByte[7:4] == 4'h0 ##1 devByteValid)
    else $error("bad read");
  write_quiet_a: assert property (linkFirst && linkByte == 8'h54 |=> !devByteValid [*4])
    else $error("write answered");
  byte_answer_a: assert property (devByteValid |-> $past(linkStrobe)) else $error("stray byte");
  conv_busy_a: assert property (wr_conv |=> busy) else $error("no busy");
endmodule

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
  logic rdChk = 1'b0, pend = 1'b0, measValid = 1'b0;
  logic [2:0] evt = 3'h0;
  logic [7:0] regAddr = 8'h00;
  logic [11:0] measData = 12'h000;
  logic [31:0] regWdata = 32'h0, seed = 32'hDDB18D46, d, regRdata;
  logic [9:0] gains;
  logic [7:0] trim1;
  logic g1, g1Oe, g2, f, fOe;
  logic [31:0] expQ[$];
  logic [11:0] rstv[4] = '{12'h7FF, 12'h800, 12'hFFF, 12'h000};
  int fail_count = 0, num_checks = 0, n;
  always #2 ref_clk = ~ref_clk;
  tabs_if link ();
  tabs_device i_tabs_device (.ref_clk, .resetn, .link, .convertStartPin(evt[2]), .measValid,
    .measChan(1'b0), .measIsTemp(1'b1), .measData, .convDone(evt[0]), .scanDone(evt[1]),
    .calConvActive(1'b0), .dacCalActive(1'b0), .offsetAbove(2'h0), .convStart(),
    .convTimingSel(), .convContinuous(), .oscPowerdown(), .ampGainCh1(gains[9:5]),
    .ampGainCh2(gains[4:0]), .ampTrimCh1(trim1), .ampTrimCh2(), .ch1GuardOut(g1),
    .ch1GuardOe(g1Oe), .ch2GuardOut(g2), .ch2GuardOe(), .faultOut(f), .faultOe(fOe));
  tabs_host i_tabs_host (.ref_clk, .resetn, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .link);
  tabs_chk i_tabs_chk (.ref_clk, .resetn, .linkStrobe(link.linkStrobe),
    .linkFirst(link.linkFirst), .linkByte(link.linkByte), .devByte(link.devByte),
    .devByteValid(link.devByteValid), .busy(link.busy));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(string nm, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      $display("wrong value %s: expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Read data lands one cycle after the strobe, so the note is taken then
  always @(posedge ref_clk) begin
    if (pend) check("regRdata", expQ.pop_front(), regRdata);
    pend <= regRead && rdChk;
  end
  task automatic hwr(logic [7:0] a, logic [31:0] v);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= v;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  task automatic hrd(logic [7:0] a, logic [31:0] e, logic c);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    rdChk <= c;
    if (c) expQ.push_back(e);
    @(posedge ref_clk);
    regRead <= 1'b0;
  endtask
  task automatic xfer(logic [7:0] c, logic [15:0] v);
    hwr(8'h04, {16'h0, v});
    hwr(8'h00, {24'h0, c});
    for (n = 0; n < 300; n++) begin
      hrd(8'h0C, 32'h0, 1'b0);
      @(posedge ref_clk);
      if (regRdata[0] === 1'b0) break;
    end
    if (n == 300) begin
      fail_count++;
      close_out();
    end
  endtask
  task automatic bz(logic b);
    check("busy", {31'h0, b}, {31'h0, link.busy});
  endtask
  task automatic pins(logic [4:0] e);
    check("pins", {27'h0, e}, {27'h0, g1, g1Oe, g2, f, fOe});
  endtask
  task automatic ev(int i, logic b);
    @(posedge ref_clk);
    evt[i] <= 1'b1;
    @(posedge ref_clk);
    evt[i] <= 1'b0;
    @(posedge ref_clk);
    #1 bz(b);
  endtask
  task automatic meas(logic [11:0] v, logic [4:0] e);
    @(posedge ref_clk);
    measValid <= 1'b1;
    measData <= v;
    @(posedge ref_clk);
    measValid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 pins(e);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    #1 pins(5'h0B);
    for (int i = 0; i < 8; i++) begin
      d = rnd();
      xfer(8'hA0 + 8'(2 * i), 16'h0);
      hrd(8'h08, {20'h0, rstv[i % 4]}, 1'b1);
      xfer(8'h20 + 8'(2 * i), d[15:0]);
      xfer(8'hA0 + 8'(2 * i), 16'h0);
      hrd(8'h08, {20'h0, d[11:0]}, 1'b1);
    end
    hrd(8'h10, 32'h0, 1'b1);
    $display("test thresholds done");
    xfer(8'h20, 16'h0100);
    xfer(8'h22, 16'h0800);
    xfer(8'h60, 16'h0004);
    meas(12'h120, 5'h1B);
    meas(12'h0FC, 5'h1B);
    meas(12'h0F8, 5'h09);
    xfer(8'h32, 16'h0031);
    meas(12'h120, 5'h1B);
    meas(12'h0FF, 5'h09);
    xfer(8'h60, 16'h0005);
    meas(12'h120, 5'h1B);
    meas(12'h0F0, 5'h0B);
    xfer(8'hEA, 16'h0);
    hrd(8'h08, 32'h1, 1'b1);
    pins(5'h09);
    xfer(8'h60, 16'h000A);
    pins(5'h08);
    meas(12'h120, 5'h01);
    $display("test alarms done");
    xfer(8'h62, 16'h0003);
    bz(1'b1);
    ev(0, 1'b0);
    xfer(8'h62, 16'h0000);
    ev(0, 1'b1);
    ev(1, 1'b0);
    xfer(8'h62, 16'h0004);
    bz(1'b0);
    xfer(8'h62, 16'h0000);
    bz(1'b1);
    ev(1, 1'b0);
    ev(2, 1'b1);
    ev(1, 1'b0);
    $display("test busy done");
    xfer(8'h30, 16'h0009);
    check("gain", 32'({tabs_pkg::GAIN_MID, tabs_pkg::GAIN_HIGH}), 32'(gains));
    xfer(8'h4E, 16'h0001);
    bz(1'b1);
    for (n = 0; n < 400 && link.busy; n++) @(posedge ref_clk);
    if (n == 400) begin
      fail_count++;
      close_out();
    end
    check("trim", 32'(tabs_pkg::TRIM_MAX), 32'(trim1));
    bz(1'b0);
    $display("test amplifier done");
    close_out();
  end
endmodule

// ==== verilog/tabs_device.sv ====
`timescale 1ns/1ps
// Behaviour
// - Comparator mode: fault equals guard1 OR guard2
// - Latched mode: fault holds until flags read
// - Comparator mode: fault clears when readings recover
// - Fault pin drive and polarity configurable
// - Guards active-high push-pull, open-drain optional
// - Busy covers conversions, calibrations, power-up init
// - Link always served regardless of busy
// - Host waits busy low for FIFO, conversions
// - Busy rises clock after conversion start
// - Single mode: busy until conversion checked
// - Scan modes: busy until last channel checked
// - Continuous: no busy; stop busy until halt
// - Host waits busy low before oscillator powerdown
// - Window mode: outside trips, hysteresis to clear
// - Window hysteresis 8 to 64 LSBs
// - Hysteresis mode: above trips, below clears
// - All registers reset to defaults
// - Threshold write sixteen bits, upper four ignored
// - Temperature compares signed, eighth-degree LSB
// - Gain 2, 10 or 25 per channel
// - Offset trim swept over plus/minus 3mV
// - Frame: address byte, command byte, data
module tabs_device #(
  parameter logic [6:0] DEV_ADDR = tabs_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic resetn,
  tabs_if.dev link,
  input wire logic convertStartPin,
  input wire logic measValid,
  input wire logic measChan,
  input wire logic measIsTemp,
  input wire logic [11:0] measData,
  input wire logic convDone,
  input wire logic scanDone,
  input wire logic calConvActive,
  input wire logic dacCalActive,
  input wire logic [1:0] offsetAbove,
  output logic convStart,
  output logic [1:0] convTimingSel,
  output logic convContinuous,
  output logic oscPowerdown,
  output logic [4:0] ampGainCh1,
  output logic [4:0] ampGainCh2,
  output logic [7:0] ampTrimCh1,
  output logic [7:0] ampTrimCh2,
  output logic ch1GuardOut,
  output logic ch1GuardOe,
  output logic ch2GuardOut,
  output logic ch2GuardOe,
  output logic faultOut,
  output logic faultOe
);

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [11:0] thrRst(input logic [2:0] idx);
    case (idx[1:0])
      2'h0: return tabs_pkg::THR_RST_HIGH_TEMP;
      2'h1: return tabs_pkg::THR_RST_LOW_TEMP;
      2'h2: return tabs_pkg::THR_RST_HIGH_CUR;
      default: return tabs_pkg::THR_RST_LOW_CUR;
    endcase
  endfunction

  function automatic logic [4:0] gainOf(input logic [1:0] code);
    case (code)
      2'h0: return tabs_pkg::GAIN_LOW;
      2'h1: return tabs_pkg::GAIN_MID;
      default: return tabs_pkg::GAIN_HIGH;
    endcase
  endfunction

  function automatic logic signed [13:0] ext12(input logic [11:0] v, input logic sgn);
    return sgn ? $signed({{2{v[11]}}, v}) : $signed({2'h0, v});
  endfunction

  function automatic logic nextCond(input logic cur, input logic signed [13:0] x,
                                    input logic signed [13:0] hi,
                                    input logic signed [13:0] lo,
                                    input logic signed [13:0] hy, input logic hysMode);
    if (hysMode) begin
      if (x > hi) return 1'b1;
      if (x < hi) return 1'b0;
      return cur;
    end
    if (x < lo || x > hi) return 1'b1;
    if (x >= lo + hy && x <= hi - hy) return 1'b0;
    return cur;
  endfunction

  // Open-drain drives low only; the pull-up supplies the high level
  function automatic logic [1:0] pinDrive(input logic level, input logic od);
    return od ? {1'b0, ~level} : {level, 1'b1};
  endfunction

  // ------------------------------------------------------------------
  // Link receive
  // ------------------------------------------------------------------
  logic [1:0] byteCnt_q;
  logic sel_q;
  logic rdFrame_q;
  logic [7:0] cmd_q;
  logic [7:0] hiByte_q;
  logic [15:0] rdWord_q;
  logic [7:0] devByte_q;
  logic devByteValid_q;
  logic wrEn;
  logic rdCmdByte;
  logic [15:0] wrData;
  logic [15:0] rdMux;

  logic [11:0] thr_q [8];
  logic [7:0] hwCfg_q;
  logic [7:0] softCfg_q;
  logic [7:0] devCfg_q;
  logic [7:0] conv_q;
  logic [7:0] shut_q;
  logic [3:0] flag_q;
  logic [3:0] cond_q;
  logic [3:0] condD;

  // Frames are never gated by busy, so the host can poll at any time
  assign wrEn = link.linkStrobe && !link.linkFirst && sel_q && !rdFrame_q
                && byteCnt_q == 2'h3;
  assign rdCmdByte = link.linkStrobe && !link.linkFirst && sel_q && rdFrame_q
                     && byteCnt_q == 2'h1;
  assign wrData = {4'h0, hiByte_q[3:0], link.linkByte};

  always_comb begin
    rdMux = 16'h0000;
    if (link.linkByte[7:4] == tabs_pkg::CMD_THR_RD_NIB && !link.linkByte[0]) begin
      rdMux = {4'h0, thr_q[link.linkByte[3:1]]};
    end else begin
      case (link.linkByte)
        tabs_pkg::CMD_DEV_CFG_RD: rdMux = {8'h00, devCfg_q};
        tabs_pkg::CMD_SOFT_CFG_RD: rdMux = {8'h00, softCfg_q};
        tabs_pkg::CMD_HW_CFG_RD: rdMux = {8'h00, hwCfg_q};
        tabs_pkg::CMD_FLAG_RD: rdMux = {12'h000, flag_q};
        default: rdMux = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      byteCnt_q <= 2'h0;
      sel_q <= 1'b0;
      rdFrame_q <= 1'b0;
      cmd_q <= 8'h00;
      hiByte_q <= 8'h00;
      rdWord_q <= 16'h0000;
      devByte_q <= 8'h00;
      devByteValid_q <= 1'b0;
    end else begin
      devByteValid_q <= 1'b0;
      if (link.linkStrobe && link.linkFirst) begin
        sel_q <= link.linkByte[7:1] == DEV_ADDR;
        rdFrame_q <= link.linkByte[0];
        byteCnt_q <= 2'h1;
      end else if (link.linkStrobe && sel_q) begin
        byteCnt_q <= byteCnt_q + 2'h1;
        case (byteCnt_q)
          2'h1: begin
            cmd_q <= link.linkByte;
            rdWord_q <= rdMux;
          end
          2'h2: begin
            hiByte_q <= link.linkByte;
            devByte_q <= rdWord_q[15:8];
            devByteValid_q <= rdFrame_q;
          end
          2'h3: begin
            devByte_q <= rdWord_q[7:0];
            devByteValid_q <= rdFrame_q;
            sel_q <= 1'b0;
          end
          default: sel_q <= 1'b0;
        endcase
      end
    end
  end

  assign link.devByte = devByte_q;
  assign link.devByteValid = devByteValid_q;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 8; i++) begin
        thr_q[i] <= thrRst(3'(i));
      end
      hwCfg_q <= tabs_pkg::HW_CFG_RST;
      softCfg_q <= tabs_pkg::SOFT_CFG_RST;
      devCfg_q <= tabs_pkg::DEV_CFG_RST;
      conv_q <= tabs_pkg::CONV_RST;
      shut_q <= tabs_pkg::SHUT_RST;
    end else if (wrEn) begin
      if (cmd_q[7:4] == tabs_pkg::CMD_THR_WR_NIB && !cmd_q[0]) begin
        thr_q[cmd_q[3:1]] <= wrData[11:0];
      end
      case (cmd_q)
        tabs_pkg::CMD_HW_CFG_WR: hwCfg_q <= wrData[7:0];
        tabs_pkg::CMD_SOFT_CFG_WR: softCfg_q <= wrData[7:0];
        tabs_pkg::CMD_DEV_CFG_WR: devCfg_q <= wrData[7:0];
        tabs_pkg::CMD_CONV_WR: conv_q <= wrData[7:0];
        tabs_pkg::CMD_SHUT_WR: shut_q <= wrData[7:0];
        default: ;
      endcase
    end
  end

  assign convTimingSel = conv_q[tabs_pkg::CONV_TSEL_LSB +: 2];
  assign convContinuous = conv_q[tabs_pkg::CONV_CONT_BIT];
  assign oscPowerdown = shut_q[tabs_pkg::SHUT_OSC_POWERDOWN_BIT_BIT];
  assign ampGainCh1 = gainOf(devCfg_q[tabs_pkg::DEV_GAIN1_LSB +: 2]);
  assign ampGainCh2 = gainOf(devCfg_q[tabs_pkg::DEV_GAIN2_LSB +: 2]);

  // ------------------------------------------------------------------
  // Threshold comparison; condition k = channel*2 + (current ? 1 : 0)
  // ------------------------------------------------------------------
  always_comb begin
    logic signed [13:0] hy;
    logic isTemp;
    hy = $signed(14'({11'h000, softCfg_q[tabs_pkg::SOFT_HYST_LSB +: 3]} + 14'h0001)
                 * tabs_pkg::HYST_STEP);
    isTemp = 1'b0;
    condD = cond_q;
    for (int k = 0; k < 4; k++) begin
      isTemp = (k % 2) == 0;
      if (measValid && measChan == 1'(k / 2) && measIsTemp == isTemp
          && softCfg_q[isTemp ? tabs_pkg::SOFT_TEMP_EN_BIT : tabs_pkg::SOFT_CUR_EN_BIT]) begin
        condD[k] = nextCond(cond_q[k], ext12(measData, isTemp),
                            ext12(thr_q[2 * k], isTemp), ext12(thr_q[2 * k + 1], isTemp),
                            hy, softCfg_q[tabs_pkg::SOFT_HYSMODE_BIT]);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cond_q <= 4'h0;
    end else begin
      cond_q <= condD;
    end
  end

  // Set wins over the read-clear so a trip during the read is kept
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flag_q <= 4'h0;
    end else begin
      flag_q <= (rdCmdByte && link.linkByte == tabs_pkg::CMD_FLAG_RD ? 4'h0 : flag_q)
                | (condD & ~cond_q);
    end
  end

  // ------------------------------------------------------------------
  // Output pins
  // ------------------------------------------------------------------
  logic guard1;
  logic guard2;
  logic faultActive;
  assign guard1 = cond_q[0] | cond_q[1];
  assign guard2 = cond_q[2] | cond_q[3];
  assign faultActive = hwCfg_q[tabs_pkg::HW_FAULT_LATCH_BIT] ? |flag_q
                       : guard1 | guard2;
  assign {ch1GuardOut, ch1GuardOe} = pinDrive(guard1, hwCfg_q[tabs_pkg::HW_G1_OD_BIT]);
  assign {ch2GuardOut, ch2GuardOe} = pinDrive(guard2, hwCfg_q[tabs_pkg::HW_G2_OD_BIT]);
  assign {faultOut, faultOe} = pinDrive(faultActive ^ ~hwCfg_q[tabs_pkg::HW_FAULT_AH_BIT],
                                        hwCfg_q[tabs_pkg::HW_FAULT_OD_BIT]);

  // ------------------------------------------------------------------
  // Conversion sequencing
  // ------------------------------------------------------------------
  tabs_pkg::tabs_conv_e conv_st_q;
  logic convCmd;
  assign convCmd = wrEn && cmd_q == tabs_pkg::CMD_CONV_WR;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      conv_st_q <= tabs_pkg::CV_IDLE;
      convStart <= 1'b0;
    end else begin
      convStart <= 1'b0;
      case (conv_st_q)
        tabs_pkg::CV_IDLE: begin
          if (convCmd && wrData[tabs_pkg::CONV_CONT_BIT]) begin
            conv_st_q <= tabs_pkg::CV_CONT;
            convStart <= 1'b1;
          end else if (convCmd || convertStartPin) begin
            conv_st_q <= tabs_pkg::CV_RUN;
            convStart <= 1'b1;
          end
        end
        tabs_pkg::CV_RUN: begin
          if (convTimingSel == tabs_pkg::TSEL_SINGLE ? convDone : scanDone) begin
            conv_st_q <= tabs_pkg::CV_IDLE;
          end
        end
        tabs_pkg::CV_CONT: begin
          if (convCmd && !wrData[tabs_pkg::CONV_CONT_BIT]) begin
            conv_st_q <= tabs_pkg::CV_STOP;
          end
        end
        tabs_pkg::CV_STOP: begin
          if (scanDone) conv_st_q <= tabs_pkg::CV_IDLE;
        end
        default: conv_st_q <= tabs_pkg::CV_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Power-up init and amplifier offset calibration
  // ------------------------------------------------------------------
  logic [15:0] initCnt_q;
  logic [1:0] calAct_q;
  logic signed [7:0] trim_q [2];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      initCnt_q <= 16'(tabs_pkg::INIT_CYCLES);
    end else if (initCnt_q != 16'h0000) begin
      initCnt_q <= initCnt_q - 16'h0001;
    end
  end

  // Linear sweep from the negative end: stops at the first code that
  // pushes the net offset positive, i.e. the code nearest zero offset
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      calAct_q <= 2'h0;
      trim_q[0] <= 8'h00;
      trim_q[1] <= 8'h00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (wrEn && cmd_q == tabs_pkg::CMD_AMPCAL_WR && wrData[c]) begin
          calAct_q[c] <= 1'b1;
          trim_q[c] <= -tabs_pkg::TRIM_MAX;
        end else if (calAct_q[c]) begin
          if (offsetAbove[c] || trim_q[c] == tabs_pkg::TRIM_MAX) begin
            calAct_q[c] <= 1'b0;
          end else begin
            trim_q[c] <= trim_q[c] + 8'sh01;
          end
        end
      end
    end
  end

  assign ampTrimCh1 = trim_q[0];
  assign ampTrimCh2 = trim_q[1];

  assign link.busy = conv_st_q == tabs_pkg::CV_RUN || conv_st_q == tabs_pkg::CV_STOP
                     || calConvActive || dacCalActive || initCnt_q != 16'h0000
                     || |calAct_q;

endmodule

// ==== verilog/tabs_host.sv ====
`timescale 1ns/1ps
module tabs_host #(
  parameter logic [6:0] DEV_ADDR = tabs_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  tabs_if.host link
);

  // ------------------------------------------------------------------
  // Order gating
  // ------------------------------------------------------------------
  // Conversions, FIFO reads and oscillator shutdown must not overlap busy
  function automatic logic needsIdle(input logic [7:0] cmd, input logic [15:0] data);
    return cmd == tabs_pkg::CMD_CONV_WR || cmd == tabs_pkg::CMD_FIFO_RD
           || (cmd == tabs_pkg::CMD_SHUT_WR && data[tabs_pkg::SHUT_OSC_POWERDOWN_BIT_BIT]);
  endfunction

  tabs_pkg::tabs_host_e st_q;
  logic [7:0] cmd_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic isRead;

  assign isRead = cmd_q[tabs_pkg::CMD_RD_BIT];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wdata_q <= 16'h0000;
    end else if (regWrite && regAddr == tabs_pkg::HOST_REG_WDATA && st_q == tabs_pkg::HS_IDLE) begin
      wdata_q <= regWdata[15:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= tabs_pkg::HS_IDLE;
      cmd_q <= 8'h00;
    end else begin
      case (st_q)
        tabs_pkg::HS_IDLE: begin
          if (regWrite && regAddr == tabs_pkg::HOST_REG_CMD) begin
            cmd_q <= regWdata[7:0];
            st_q <= tabs_pkg::HS_WAIT;
          end
        end
        tabs_pkg::HS_WAIT: begin
          if (!(needsIdle(cmd_q, wdata_q) && link.busy)) st_q <= tabs_pkg::HS_ADDR;
        end
        tabs_pkg::HS_ADDR: st_q <= tabs_pkg::HS_CMD;
        tabs_pkg::HS_CMD: st_q <= tabs_pkg::HS_D0;
        tabs_pkg::HS_D0: st_q <= tabs_pkg::HS_D1;
        tabs_pkg::HS_D1: st_q <= tabs_pkg::HS_DONE;
        tabs_pkg::HS_DONE: st_q <= tabs_pkg::HS_IDLE;
        default: st_q <= tabs_pkg::HS_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Link bytes: address, command, two data bytes
  // ------------------------------------------------------------------
  always_comb begin
    link.linkStrobe = 1'b1;
    link.linkFirst = 1'b0;
    link.linkByte = 8'h00;
    case (st_q)
      tabs_pkg::HS_ADDR: begin
        link.linkFirst = 1'b1;
        link.linkByte = {DEV_ADDR, isRead};
      end
      tabs_pkg::HS_CMD: link.linkByte = cmd_q;
      tabs_pkg::HS_D0: link.linkByte = isRead ? 8'h00 : wdata_q[15:8];
      tabs_pkg::HS_D1: link.linkByte = isRead ? 8'h00 : wdata_q[7:0];
      default: link.linkStrobe = 1'b0;
    endcase
  end

  // High byte arrives first, low byte one cycle later
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 16'h0000;
    end else if (link.devByteValid) begin
      rdata_q <= {rdata_q[7:0], link.devByte};
    end
  end

  // ------------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata <= 32'h00000000;
    end else if (regRead) begin
      case (regAddr)
        tabs_pkg::HOST_REG_CMD: regRdata <= {24'h000000, cmd_q};
        tabs_pkg::HOST_REG_WDATA: regRdata <= {16'h0000, wdata_q};
        tabs_pkg::HOST_REG_RDATA: regRdata <= {16'h0000, rdata_q};
        tabs_pkg::HOST_REG_STATUS: regRdata <= {29'h0000000,
                                                st_q == tabs_pkg::HS_WAIT && link.busy,
                                                link.busy, st_q != tabs_pkg::HS_IDLE};
        default: regRdata <= 32'h00000000;
      endcase
    end else begin
      regRdata <= 32'h00000000;
    end
  end

endmodule

// ==== verilog/tabs_if.sv ====
`timescale 1ns/1ps
interface tabs_if;
  logic linkStrobe;
  logic linkFirst;
  logic [7:0] linkByte;
  logic [7:0] devByte;
  logic devByteValid;
  logic busy;

  modport dev (input linkStrobe, input linkFirst, input linkByte,
               output devByte, output devByteValid, output busy);
  modport host (output linkStrobe, output linkFirst, output linkByte,
                input devByte, input devByteValid, input busy);
endinterface

// ==== verilog/tabs_pkg.sv ====
package tabs_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ = 250;
  localparam int INIT_TIME_NS = 1000;
  localparam int INIT_CYCLES = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int TRIM_SPAN_UV = 3000;
  localparam int TRIM_STEP_UV = 25;
  localparam logic signed [7:0] TRIM_MAX = 8'(TRIM_SPAN_UV / TRIM_STEP_UV);

  // ------------------------------------------------------------------
  // Link command bytes
  // ------------------------------------------------------------------
  localparam logic [3:0] CMD_THR_WR_NIB = 4'h2;
  localparam logic [3:0] CMD_THR_RD_NIB = 4'hA;
  localparam logic [7:0] CMD_DEV_CFG_WR = 8'h30;
  localparam logic [7:0] CMD_DEV_CFG_RD = 8'hB0;
  localparam logic [7:0] CMD_SOFT_CFG_WR = 8'h32;
  localparam logic [7:0] CMD_SOFT_CFG_RD = 8'hB2;
  localparam logic [7:0] CMD_HW_CFG_WR = 8'h60;
  localparam logic [7:0] CMD_HW_CFG_RD = 8'hE0;
  localparam logic [7:0] CMD_FLAG_RD = 8'hEA;
  localparam logic [7:0] CMD_CONV_WR = 8'h62;
  localparam logic [7:0] CMD_SHUT_WR = 8'h64;
  localparam logic [7:0] CMD_AMPCAL_WR = 8'h4E;
  localparam logic [7:0] CMD_FIFO_RD = 8'h80;
  localparam int CMD_RD_BIT = 7;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;

  // ------------------------------------------------------------------
  // Threshold resets (index = command bits 3:1)
  // ------------------------------------------------------------------
  localparam logic [11:0] THR_RST_HIGH_TEMP = 12'h7FF;
  localparam logic [11:0] THR_RST_LOW_TEMP = 12'h800;
  localparam logic [11:0] THR_RST_HIGH_CUR = 12'hFFF;
  localparam logic [11:0] THR_RST_LOW_CUR = 12'h000;

  // ------------------------------------------------------------------
  // Configuration fields
  // ------------------------------------------------------------------
  localparam int HW_FAULT_LATCH_BIT = 0;
  localparam int HW_FAULT_OD_BIT = 1;
  localparam int HW_FAULT_AH_BIT = 2;
  localparam int HW_G1_OD_BIT = 3;
  localparam int HW_G2_OD_BIT = 4;
  localparam logic [7:0] HW_CFG_RST = 8'h00;
  localparam int SOFT_HYSMODE_BIT = 0;
  localparam int SOFT_HYST_LSB = 1;
  localparam int SOFT_TEMP_EN_BIT = 4;
  localparam int SOFT_CUR_EN_BIT = 5;
  localparam logic [7:0] SOFT_CFG_RST = 8'h30;
  localparam logic [13:0] HYST_STEP = 14'h0008;
  localparam int DEV_GAIN1_LSB = 0;
  localparam int DEV_GAIN2_LSB = 2;
  localparam logic [7:0] DEV_CFG_RST = 8'h00;
  localparam logic [4:0] GAIN_LOW = 5'h02;
  localparam logic [4:0] GAIN_MID = 5'h0A;
  localparam logic [4:0] GAIN_HIGH = 5'h19;
  localparam int CONV_TSEL_LSB = 0;
  localparam int CONV_CONT_BIT = 2;
  localparam logic [7:0] CONV_RST = 8'h00;
  localparam logic [1:0] TSEL_SINGLE = 2'h3;
  localparam int SHUT_OSC_POWERDOWN_BIT_BIT = 0;
  localparam logic [7:0] SHUT_RST = 8'h00;

  // ------------------------------------------------------------------
  // Host register map
  // ------------------------------------------------------------------
  localparam logic [7:0] HOST_REG_CMD = 8'h00;
  localparam logic [7:0] HOST_REG_WDATA = 8'h04;
  localparam logic [7:0] HOST_REG_RDATA = 8'h08;
  localparam logic [7:0] HOST_REG_STATUS = 8'h0C;

  typedef enum logic [3:0] {
    CV_IDLE = 4'b0001,
    CV_RUN = 4'b0010,
    CV_CONT = 4'b0100,
    CV_STOP = 4'b1000
  } tabs_conv_e;

  typedef enum logic [6:0] {
    HS_IDLE = 7'b0000001,
    HS_WAIT = 7'b0000010,
    HS_ADDR = 7'b0000100,
    HS_CMD = 7'b0001000,
    HS_D0 = 7'b0010000,
    HS_D1 = 7'b0100000,
    HS_DONE = 7'b1000000
  } tabs_host_e;

endpackage
